// ===== inc/laie_pkg.sv
// constants and types for the latch and interlock executor
package laie_pkg;
	typedef logic [3:0]  laie_op_type;
	typedef logic [3:0]  laie_addr_type;
	typedef logic [15:0] laie_word_type;
	typedef logic [2:0]  laie_flags_type;

	localparam laie_op_type OP_NOP     = 4'h0;
	localparam laie_op_type OP_OUT     = 4'h1;
	localparam laie_op_type OP_OUT_NOT = 4'h2;
	localparam laie_op_type OP_KEEP    = 4'h3;
	localparam laie_op_type OP_RISE    = 4'h4;
	localparam laie_op_type OP_FALL    = 4'h5;
	localparam laie_op_type OP_DELAY      = 4'h6;
	localparam laie_op_type OP_DOWN_COUNT = 4'h7;
	localparam laie_op_type OP_REV_COUNT  = 4'h8;
	localparam laie_op_type OP_GATE_ST = 4'h9;
	localparam laie_op_type OP_GATE_END = 4'ha;
	localparam laie_op_type OP_FLAGS   = 4'hb;

	localparam int unsigned  NUM_BITS     = 16;
	localparam int unsigned  RETAIN_BASE  = 8;
	localparam int unsigned  CLK_PERIOD_NS = 10;
	localparam int unsigned  TIME_UNIT_NS = 10_000_000;
	localparam int unsigned  TICK_CYCLES_DEF = TIME_UNIT_NS / CLK_PERIOD_NS;
	localparam laie_word_type DELAY_SET_VALUE = 16'h0096;
	localparam laie_word_type DOWN_SET_VALUE  = 16'h000a;
	localparam laie_word_type REV_RESET_VALUE = 16'h0000;
	localparam laie_flags_type FLAGS_RST  = 3'h0;
endpackage

// ===== logic/laie_counter.sv
// counting element: down counter or reversible counter
module laie_counter #(
	parameter bit                    REVERSIBLE = 1'b0,
	parameter laie_pkg::laie_word_type SET_VALUE = 16'h0000
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// execution
	input  wire logic              exec,
	input  wire logic              count_in,
	input  wire logic              aux_in,
	// state
	output laie_pkg::laie_word_type present_value
);
	import laie_pkg::*;

	logic prev;

	// input edge remembered only when executed
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev <= 1'b0;
		end else if (exec) begin
			prev <= count_in;
		end
	end

	// reversible: aux selects up; down counter: aux resets to set value
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			present_value <= SET_VALUE;
		end else if (exec) begin
			if (!REVERSIBLE && aux_in) begin
				present_value <= SET_VALUE;
			end else if (count_in && !prev) begin
				if (REVERSIBLE && aux_in) begin
					present_value <= present_value + 16'h0001;
				end else if (REVERSIBLE || present_value != 16'h0000) begin
					present_value <= present_value - 16'h0001;
				end
			end
		end
	end
endmodule // laie_counter

// ===== logic/laie_exec.sv
// scan executor for latch coils, pulses, and interlocked sections
module laie_exec #(
	parameter int unsigned TICK_CYCLES = laie_pkg::TICK_CYCLES_DEF
) (
	// clock and reset
	input  wire logic                  CLK_SYS,
	input  wire logic                  NRST,
	// instruction stream, one per cycle
	input  wire logic                  INSTR_VALID,
	input  laie_pkg::laie_op_type      INSTR_OP,
	input  laie_pkg::laie_addr_type    INSTR_ADDR,
	input  wire logic                  INSTR_COND,
	input  wire logic                  INSTR_AUX,
	// bit area and flags
	output laie_pkg::laie_word_type    BITS,
	output laie_pkg::laie_flags_type   FLAGS,
	output logic                       GATE_OFF,
	// timer and counter state
	output laie_pkg::laie_word_type    DELAY_VALUE,
	output logic                       DELAY_DONE,
	output laie_pkg::laie_word_type    DOWN_VALUE,
	output laie_pkg::laie_word_type    REV_VALUE
);
	import laie_pkg::*;

	localparam int unsigned HI_BITS = NUM_BITS - RETAIN_BASE;

	logic [RETAIN_BASE-1:0] lo_bits;
	logic [HI_BITS-1:0]     hi_bits;
	logic [NUM_BITS-1:0]    prev_cond;
	logic [31:0]            div_count;
	logic                   tick;
	logic                   cur;
	logic                   next_we;
	logic                   next_val;
	logic                   next_prev_we;
	logic                   exec_delay;
	logic                   exec_down;
	logic                   exec_rev;

	assign BITS = {hi_bits, lo_bits};
	assign cur  = BITS[INSTR_ADDR];

	// time unit divider
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			div_count <= 32'h0;
			tick      <= 1'b0;
		end else if (div_count == 32'(TICK_CYCLES - 1)) begin
			div_count <= 32'h0;
			tick      <= 1'b1;
		end else begin
			div_count <= div_count + 32'h1;
			tick    <= 1'b0;
		end
	end

	// bit instruction evaluation
	always_comb begin
		next_we      = 1'b0;
		next_val     = cur;
		next_prev_we = 1'b0;
		if (INSTR_VALID) begin
			case (INSTR_OP)
				OP_OUT: begin
					next_we  = 1'b1;
					next_val = !GATE_OFF && INSTR_COND;
				end
				OP_OUT_NOT: begin
					next_we  = 1'b1;
					next_val = !GATE_OFF && !INSTR_COND;
				end
				OP_KEEP: begin
					next_we  = !GATE_OFF;
					if (INSTR_AUX) begin
						next_val = 1'b0;
					end else if (INSTR_COND) begin
						next_val = 1'b1;
					end
				end
				OP_RISE: begin
					next_we      = !GATE_OFF;
					next_prev_we = !GATE_OFF;
					next_val     = INSTR_COND && !prev_cond[INSTR_ADDR];
				end
				OP_FALL: begin
					next_we      = !GATE_OFF;
					next_prev_we = !GATE_OFF;
					next_val     = !INSTR_COND && prev_cond[INSTR_ADDR];
				end
				default: begin
					next_we = 1'b0;
				end
			endcase
		end
	end

	// volatile bits cleared on power-up
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			lo_bits <= '0;
		end else if (next_we && INSTR_ADDR < 4'(RETAIN_BASE)) begin
			lo_bits[INSTR_ADDR[2:0]] <= next_val;
		end
	end

	// retained area has no reset so it survives power loss
	always_ff @(posedge CLK_SYS) begin
		if (next_we && INSTR_ADDR >= 4'(RETAIN_BASE)) begin
			hi_bits[INSTR_ADDR[2:0]] <= next_val;
		end
	end

	// pulse history frozen while gated off
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			prev_cond <= '0;
		end else if (next_prev_we) begin
			prev_cond[INSTR_ADDR] <= INSTR_COND;
		end
	end

	// interlock gate: any OFF start closes until the end
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			GATE_OFF <= 1'b0;
		end else if (INSTR_VALID && INSTR_OP == OP_GATE_END) begin
			GATE_OFF <= 1'b0;
		end else if (INSTR_VALID && INSTR_OP == OP_GATE_ST && !INSTR_COND) begin
			GATE_OFF <= 1'b1;
		end
	end

	// flags touched only by the flag load instruction
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			FLAGS <= FLAGS_RST;
		end else if (INSTR_VALID && INSTR_OP == OP_FLAGS && !GATE_OFF) begin
			FLAGS <= INSTR_ADDR[2:0];
		end
	end

	assign exec_delay = INSTR_VALID && INSTR_OP == OP_DELAY;
	assign exec_down  = INSTR_VALID && INSTR_OP == OP_DOWN_COUNT && !GATE_OFF;
	assign exec_rev   = INSTR_VALID && INSTR_OP == OP_REV_COUNT && !GATE_OFF;

	laie_timer u_delay (
		.clk           (CLK_SYS),
		.nrst          (NRST),
		.tick          (tick),
		.exec          (exec_delay),
		.cond          (INSTR_COND),
		.gated         (GATE_OFF),
		.present_value (DELAY_VALUE),
		.done          (DELAY_DONE)
	);

	laie_counter #(.REVERSIBLE(1'b0), .SET_VALUE(DOWN_SET_VALUE)) u_down (
		.clk           (CLK_SYS),
		.nrst          (NRST),
		.exec          (exec_down),
		.count_in      (INSTR_COND),
		.aux_in        (INSTR_AUX),
		.present_value (DOWN_VALUE)
	);

	laie_counter #(.REVERSIBLE(1'b1), .SET_VALUE(REV_RESET_VALUE)) u_rev (
		.clk           (CLK_SYS),
		.nrst          (NRST),
		.exec          (exec_rev),
		.count_in      (INSTR_COND),
		.aux_in        (INSTR_AUX),
		.present_value (REV_VALUE)
	);

	default clocking dc @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);

	keep_set_a: assert property (
		INSTR_VALID && INSTR_OP == OP_KEEP && !GATE_OFF && INSTR_COND && !INSTR_AUX
		|=> BITS[$past(INSTR_ADDR)]
	) else $error("latch set did not turn bit on");

	keep_reset_a: assert property (
		INSTR_VALID && INSTR_OP == OP_KEEP && !GATE_OFF && INSTR_AUX
		|=> !BITS[$past(INSTR_ADDR)]
	) else $error("latch reset did not turn bit off");

	keep_gated_hold_a: assert property (
		INSTR_VALID && INSTR_OP == OP_KEEP && GATE_OFF
		|=> $stable(BITS)
	) else $error("latch bit changed while gated off");

	flags_hold_a: assert property (
		!(INSTR_VALID && INSTR_OP == OP_FLAGS) |=> $stable(FLAGS)
	) else $error("flags changed by a non-flag instruction");

	coil_gated_off_a: assert property (
		INSTR_VALID && (INSTR_OP == OP_OUT || INSTR_OP == OP_OUT_NOT) && GATE_OFF
		|=> !BITS[$past(INSTR_ADDR)]
	) else $error("coil bit not forced off under interlock");

	gate_close_a: assert property (
		INSTR_VALID && INSTR_OP == OP_GATE_ST && !INSTR_COND |=> GATE_OFF
	) else $error("gate start with off condition did not close");

	gate_clear_a: assert property (
		INSTR_VALID && INSTR_OP == OP_GATE_END |=> !GATE_OFF
	) else $error("gate end did not clear interlock");

	pulse_frozen_a: assert property (
		GATE_OFF |=> $stable(prev_cond)
	) else $error("pulse history recorded while gated");

	rise_pulse_a: assert property (
		INSTR_VALID && INSTR_OP == OP_RISE && !GATE_OFF && INSTR_COND
		&& prev_cond[INSTR_ADDR] |=> !BITS[$past(INSTR_ADDR)]
	) else $error("rise pulse held longer than one scan");

	delay_gated_a: assert property (
		exec_delay && GATE_OFF |=> DELAY_VALUE == DELAY_SET_VALUE && !DELAY_DONE
	) else $error("delay element not reset under interlock");

	count_gated_a: assert property (
		INSTR_VALID && GATE_OFF |=> $stable(DOWN_VALUE) && $stable(REV_VALUE)
	) else $error("counter changed under interlock");

	delay_idle_a: assert property (
		exec_delay && !GATE_OFF && !INSTR_COND
		|=> DELAY_VALUE == DELAY_SET_VALUE && !DELAY_DONE
	) else $error("delay element not reloaded with condition off");

	delay_step_a: assert property (
		exec_delay && !GATE_OFF && INSTR_COND && DELAY_VALUE != 16'h0000
		|=> DELAY_VALUE == $past(DELAY_VALUE) || DELAY_VALUE == $past(DELAY_VALUE) - 16'h0001
	) else $error("delay element stepped by more than one unit");

	delay_done_hold_a: assert property (
		exec_delay && !GATE_OFF && INSTR_COND && DELAY_DONE
		|=> DELAY_DONE
	) else $error("delay element lost done with condition on");

	down_reload_a: assert property (
		exec_down && INSTR_AUX |=> DOWN_VALUE == DOWN_SET_VALUE
	) else $error("down counter not reloaded by its reset input");

	keep_both_a: assert property (
		INSTR_VALID && INSTR_OP == OP_KEEP && !GATE_OFF && INSTR_COND && INSTR_AUX
		|=> !BITS[$past(INSTR_ADDR)]
	) else $error("latch set beat reset");

	keep_idle_a: assert property (
		INSTR_VALID && INSTR_OP == OP_KEEP && !INSTR_COND && !INSTR_AUX
		|=> $stable(BITS)
	) else $error("latch bit changed with both inputs off");

	out_open_a: assert property (
		INSTR_VALID && INSTR_OP == OP_OUT && !GATE_OFF
		|=> BITS[$past(INSTR_ADDR)] == $past(INSTR_COND)
	) else $error("coil bit does not follow its condition");

	out_not_open_a: assert property (
		INSTR_VALID && INSTR_OP == OP_OUT_NOT && !GATE_OFF
		|=> BITS[$past(INSTR_ADDR)] == !$past(INSTR_COND)
	) else $error("inverted coil bit does not follow its condition");

	rise_on_a: assert property (
		INSTR_VALID && INSTR_OP == OP_RISE && !GATE_OFF && INSTR_COND
		&& !prev_cond[INSTR_ADDR] |=> BITS[$past(INSTR_ADDR)]
	) else $error("rise pulse missed an off to on change");

	fall_on_a: assert property (
		INSTR_VALID && INSTR_OP == OP_FALL && !GATE_OFF && !INSTR_COND
		&& prev_cond[INSTR_ADDR] |=> BITS[$past(INSTR_ADDR)]
	) else $error("fall pulse missed an on to off change");

	fall_pulse_a: assert property (
		INSTR_VALID && INSTR_OP == OP_FALL && !GATE_OFF && !INSTR_COND
		&& !prev_cond[INSTR_ADDR] |=> !BITS[$past(INSTR_ADDR)]
	) else $error("fall pulse held longer than one scan");

	pulse_gated_a: assert property (
		INSTR_VALID && (INSTR_OP == OP_RISE || INSTR_OP == OP_FALL) && GATE_OFF
		|=> $stable(BITS)
	) else $error("pulse executed under interlock");

	flags_gated_a: assert property (
		INSTR_VALID && INSTR_OP == OP_FLAGS && GATE_OFF |=> $stable(FLAGS)
	) else $error("flag load executed under interlock");

	gate_flags_a: assert property (
		INSTR_VALID && (INSTR_OP == OP_GATE_ST || INSTR_OP == OP_GATE_END)
		|=> $stable(FLAGS)
	) else $error("gate instruction changed the flags");

	gate_stay_closed_a: assert property (
		GATE_OFF && !(INSTR_VALID && INSTR_OP == OP_GATE_END) |=> GATE_OFF
	) else $error("interlock opened before its gate end");

	gate_stay_open_a: assert property (
		!GATE_OFF && !(INSTR_VALID && INSTR_OP == OP_GATE_ST && !INSTR_COND)
		|=> !GATE_OFF
	) else $error("interlock closed without an off gate start");
endmodule // laie_exec

// ===== logic/laie_timer.sv
// on-delay element: decrementing from set value per time unit
module laie_timer (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// time base and execution
	input  wire logic              tick,
	input  wire logic              exec,
	input  wire logic              cond,
	input  wire logic              gated,
	// state
	output laie_pkg::laie_word_type present_value,
	output logic                   done
);
	import laie_pkg::*;

	logic pending;

	// tick held until the element executes; a tick wins over consumption
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pending <= 1'b0;
		end else if (tick) begin
			pending <= 1'b1;
		end else if (exec) begin
			pending <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			present_value <= DELAY_SET_VALUE;
			done          <= 1'b0;
		end else if (exec) begin
			if (gated || !cond) begin
				present_value <= DELAY_SET_VALUE;
				done          <= 1'b0;
			end else if (present_value == 16'h0000) begin
				done <= 1'b1;
			end else if (pending) begin
				present_value <= present_value - 16'h0001;
				done          <= (present_value == 16'h0001);
			end
		end
	end
endmodule // laie_timer

// ===== verif/tb_top.sv
// self-checking testbench for the latch and interlock executor
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import laie_pkg::*;

	logic           clk_sys  = 1'b0;
	logic           nrst     = 1'b0;
	logic           valid    = 1'b0;
	laie_op_type    op       = OP_NOP;
	laie_addr_type  addr     = 4'h0;
	logic           cond     = 1'b0;
	logic           aux      = 1'b0;
	laie_word_type  bits;
	laie_word_type  delay_value;
	laie_word_type  down_value;
	laie_word_type  rev_value;
	laie_flags_type flags;
	logic           gate_off;
	logic           delay_done;
	int             failures = 0;
	int             n_checks = 0;

	always #5 clk_sys = ~clk_sys;

	laie_exec #(.TICK_CYCLES(4)) DUT (
		.CLK_SYS(clk_sys), .NRST(nrst), .INSTR_VALID(valid), .INSTR_OP(op),
		.INSTR_ADDR(addr), .INSTR_COND(cond), .INSTR_AUX(aux), .BITS(bits),
		.FLAGS(flags), .GATE_OFF(gate_off), .DELAY_VALUE(delay_value),
		.DELAY_DONE(delay_done), .DOWN_VALUE(down_value), .REV_VALUE(rev_value)
	);

	// one instruction, ca = {aux, cond}
	task automatic ex(input laie_op_type o, input laie_addr_type a, input logic [1:0] ca);
		@(negedge clk_sys);
		valid = 1'b1;
		op = o;
		addr = a;
		{aux, cond} = ca;
	endtask

	task automatic idle();
		@(negedge clk_sys);
		valid = 1'b0;
	endtask

	task automatic chk(input string n, input laie_word_type e, input laie_word_type g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic t_keep();
		ex(OP_FLAGS, 4'h5, 2'h0);
		ex(OP_KEEP, 4'h2, 2'h1);
		ex(OP_KEEP, 4'h2, 2'h0);
		idle();
		chk("keep set", 16'h0001, bits[2]);
		ex(OP_KEEP, 4'h2, 2'h2);
		ex(OP_KEEP, 4'h2, 2'h0);
		idle();
		chk("keep reset", 16'h0000, bits[2]);
		ex(OP_KEEP, 4'h2, 2'h1);
		ex(OP_KEEP, 4'h2, 2'h3);
		idle();
		chk("keep both", 16'h0000, bits[2]);
		chk("keep flags", 16'h0005, flags);
		$display("test keep done");
	endtask

	task automatic t_pulse();
		ex(OP_RISE, 4'h3, 2'h1);
		ex(OP_FALL, 4'h5, 2'h1);
		idle();
		chk("rise on", 16'h0001, bits[3]);
		ex(OP_RISE, 4'h3, 2'h1);
		ex(OP_FALL, 4'h5, 2'h0);
		idle();
		chk("rise one scan", 16'h0000, bits[3]);
		chk("fall on", 16'h0001, bits[5]);
		ex(OP_FALL, 4'h5, 2'h0);
		idle();
		chk("fall one scan", 16'h0000, bits[5]);
		$display("test pulse done");
	endtask

	task automatic t_gate();
		ex(OP_OUT, 4'h4, 2'h1);
		ex(OP_OUT_NOT, 4'h1, 2'h0);
		ex(OP_KEEP, 4'h2, 2'h1);
		ex(OP_RISE, 4'h6, 2'h1);
		ex(OP_RISE, 4'h6, 2'h1);
		ex(OP_FLAGS, 4'h3, 2'h0);
		ex(OP_GATE_ST, 4'h0, 2'h1);
		ex(OP_OUT, 4'h7, 2'h1);
		ex(OP_GATE_ST, 4'h0, 2'h0);
		idle();
		chk("bits open", 16'h0096, bits[7:0]);
		chk("gate closed", 16'h0001, gate_off);
		ex(OP_OUT, 4'h4, 2'h1);
		ex(OP_OUT_NOT, 4'h1, 2'h0);
		ex(OP_KEEP, 4'h2, 2'h2);
		ex(OP_RISE, 4'h6, 2'h0);
		ex(OP_FLAGS, 4'h7, 2'h0);
		ex(OP_GATE_ST, 4'h0, 2'h1);
		ex(OP_OUT, 4'h7, 2'h1);
		idle();
		chk("bits gated", 16'h0004, bits[7:0]);
		chk("flags gated", 16'h0003, flags);
		chk("still closed", 16'h0001, gate_off);
		ex(OP_GATE_END, 4'h0, 2'h0);
		ex(OP_RISE, 4'h6, 2'h1);
		idle();
		chk("gate end", 16'h0000, gate_off);
		chk("rise history", 16'h0000, bits[6]);
		chk("flags end", 16'h0003, flags);
		$display("test gate done");
	endtask

	task automatic t_count();
		ex(OP_DELAY, 4'h0, 2'h1);
		ex(OP_DOWN_COUNT, 4'h0, 2'h0);
		ex(OP_DOWN_COUNT, 4'h0, 2'h1);
		ex(OP_REV_COUNT, 4'h0, 2'h2);
		ex(OP_REV_COUNT, 4'h0, 2'h3);
		ex(OP_GATE_ST, 4'h0, 2'h0);
		ex(OP_DELAY, 4'h0, 2'h1);
		ex(OP_DOWN_COUNT, 4'h0, 2'h0);
		ex(OP_DOWN_COUNT, 4'h0, 2'h1);
		ex(OP_REV_COUNT, 4'h0, 2'h2);
		ex(OP_REV_COUNT, 4'h0, 2'h3);
		idle();
		chk("delay reset", DELAY_SET_VALUE, delay_value);
		chk("down held", DOWN_SET_VALUE - 16'h0001, down_value);
		chk("rev held", REV_RESET_VALUE + 16'h0001, rev_value);
		ex(OP_GATE_END, 4'h0, 2'h0);
		ex(OP_DOWN_COUNT, 4'h0, 2'h2);
		ex(OP_REV_COUNT, 4'h0, 2'h0);
		ex(OP_REV_COUNT, 4'h0, 2'h1);
		ex(OP_DELAY, 4'h0, 2'h0);
		idle();
		chk("down reload", DOWN_SET_VALUE, down_value);
		chk("rev down", REV_RESET_VALUE, rev_value);
		chk("delay idle", DELAY_SET_VALUE, delay_value);
		repeat (620) ex(OP_DELAY, 4'h0, 2'h1);
		idle();
		chk("delay value", 16'h0000, delay_value);
		chk("delay done", 16'h0001, delay_done);
		$display("test count done");
	endtask

	task automatic t_retain();
		ex(OP_KEEP, 4'h8, 2'h1);
		idle();
		nrst = 1'b0;
		repeat (2) @(negedge clk_sys);
		nrst = 1'b1;
		chk("retained", 16'h0001, bits[8]);
		chk("volatile", 16'h0000, bits[7:0]);
		$display("test retain done");
	endtask

	initial begin
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		nrst = 1'b1;
		t_keep();
		t_pulse();
		t_gate();
		t_count();
		t_retain();
		complete_run();
	end

	initial begin
		repeat (3000) @(posedge clk_sys);
		failures++;
		complete_run();
	end
endmodule // tb_top
